// >>> core/ast_map.vh
`ifndef AST_MAP_VH
`define AST_MAP_VH

// Register offsets (word addresses, one byte each on lane 0)
`define AST_TX_STATUS_CONTROL  4'h0
`define AST_RX_STATUS_CONTROL  4'h1
`define AST_BAUD_CONTROL       4'h2
`define AST_BAUD_DIVISOR_LOW   4'h3
`define AST_BAUD_DIVISOR_HIGH  4'h4
`define AST_TRANSMIT_HOLDING   4'h5
`define AST_IRQ_CONTROL        4'h6

// Transmit status/control fields
`define AST_TX_CLOCKED_BIT     3'd4
`define AST_TX_ENABLE_BIT      3'd5
`define AST_TX_NINTH_MODE_BIT  3'd6
`define AST_TX_HISPEED_BIT     3'd2
`define AST_TX_SHIFT_EMPTY_BIT 3'd1
`define AST_TX_NINTH_VALUE_BIT 3'd0
// Receive status/control fields
`define AST_RX_PORT_ON_BIT     3'd7
// Baud control fields
`define AST_BC_POLARITY_BIT    3'd4
`define AST_BC_WIDE_DIV_BIT    3'd3
// Interrupt control fields
`define AST_IC_GLOBAL_BIT      3'd0
`define AST_IC_PERIPH_BIT      3'd1
`define AST_IC_TX_ENABLE_BIT   3'd2
`define AST_IC_TX_FLAG_BIT     3'd3

// Reset values
`define AST_TX_STATUS_RESET    8'h02
`define AST_CTRL_RESET         8'h00

// Frame shape: start, up to nine data, one stop
`define AST_FRAME_BITS_8       4'd10
`define AST_FRAME_BITS_9       4'd11
// Flag becomes valid on the second cycle after a holding write
`define AST_FLAG_SETTLE_CYC    2'd2

`endif

// >>> core/ast_transmitter.v
`timescale 1ns/100ps
`default_nettype none
`include "ast_map.vh"

// Register map, one byte per word on lane 0
//   0  tx status/control
//        b6 ninth-bit mode
//        b5 transmit enable
//        b4 clocked mode select
//        b2 high speed select
//        b1 shifter empty, read only
//        b0 ninth-bit value
//   1  rx status/control
//        b7 serial port on
//   2  baud control
//        b4 polarity invert
//        b3 wide divisor select
//   3  divisor low byte
//   4  divisor high byte
//   5  transmit holding register, write only, reads zero
//   6  interrupt control
//        b0 global enable
//        b1 peripheral enable
//        b2 buffer-empty interrupt enable
//        b3 buffer-empty flag, read only
//   Other addresses read zero; writes to them are acked and dropped
//
// Bus timing
//   A request is taken on the edge where cyc and stb are high and ack is low
//   Writes land on that edge; ack and read data follow one cycle later
//   Ack lasts one cycle even if the master keeps stb high
//   The master must drop stb for a cycle between requests
//
// Frame timing
//   Frame is start, eight or nine data bits lsb first, one stop bit
//   Every bit boundary falls on a baud tick, so each bit is one tick period
//   A load into an idle shifter waits for the next tick before the start bit
//   That costs up to one bit period of latency but never sends a short start bit
//   A queued character reloads on the stop bit's closing tick, so frames abut
//   The line output is registered, so it trails the shifter by one clock
//   Ninth-bit value is captured at the holding write, not at the load
//   Changing ninth-bit mode mid-frame affects only the next load
//
// Flag timing
//   The buffer-empty flag holds its value for two clocks after a holding write
//   Software polling earlier than that sees the old value
//   The flag is low while transmit enable is low
//
// Interrupt
//   Request is the flag gated by its own enable and both global enables
//   It is a level and drops one clock after any of them clears
//
// Abort
//   Port off empties holding register and shifter and parks the line at mark
//   Transmit enable off or clocked mode only stops the shifter
//   A character sitting in the holding register then waits for re-enable
//
// Limitations
//   No parity; software may carry it in the ninth bit
//   No break character and no synchronous modes; clocked select only idles the line
//   The baud tick must be one clock wide; a wider pulse shifts twice
//   Holding writes while disabled are dropped, not queued
//   A holding write over a full holding register replaces the waiting character
//   Bytes other than lane 0 are ignored on writes

module ast_transmitter
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    input  wire        baud_tick_i,
    output wire [15:0] baud_divisor_o,
    output wire        high_speed_select_o,
    output wire        wide_divisor_select_o,
    output wire        transmit_pin_o,
    output wire        transmit_pin_oe_o,
    output wire        irq_o
);

    // Bus and control registers
    reg [31:0] dat_q;
    reg        ack_q;
    reg [7:0]  txsc_q;
    reg [7:0]  rxsc_q;
    reg [7:0]  baud_ctl_q;
    reg [7:0]  div_lo_q;
    reg [7:0]  div_hi_q;
    reg [2:0]  irq_ctl_q;
    // Holding register and shifter
    reg [7:0]  hold_data_q;
    reg        hold_ninth_q;
    reg        hold_full_q;
    reg [10:0] shifter_q;
    reg [3:0]  bits_left_q;
    reg        shift_busy_q;
    reg        flag_q;
    reg        transmit_enable_ctl_prev_q;
    reg        line_q;
    reg        oe_q;
    reg        irq_q;
    reg [1:0]  settle_q;
    // Frame sequencer, one-hot
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_LEAD = 3'b010;
    localparam [2:0] ST_SEND = 3'b100;
    reg [2:0]  state_q;
    reg [2:0]  state_d;

    wire bus_req   = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr_lane0  = bus_req & wb_we_i & wb_sel_i[0];
    wire port_on   = rxsc_q[`AST_RX_PORT_ON_BIT];
    wire tx_en     = txsc_q[`AST_TX_ENABLE_BIT];
    wire clocked   = txsc_q[`AST_TX_CLOCKED_BIT];
    wire async_run = tx_en & ~clocked & port_on;
    wire hold_wr   = wr_lane0 & (wb_adr_i == `AST_TRANSMIT_HOLDING);
    wire sending   = state_q[2]; // One-hot bit of the send state
    wire last_bit  = sending & baud_tick_i & (bits_left_q == 4'd1);
    // Reload on the final tick keeps back-to-back frames gap free
    wire load_now  = async_run & hold_full_q & (~shift_busy_q | last_bit);

    // Register write decode used by every control register
    function sel_wr;
        input [3:0] adr;
        input [3:0] target;
        begin
            sel_wr = (adr == target);
        end
    endfunction

    // Wishbone slave: one wait state, ack drops after one cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= bus_req;
            dat_q <= 32'h0000_0000;
            if (bus_req & ~wb_we_i)
            begin
                case (wb_adr_i)
                    `AST_TX_STATUS_CONTROL: dat_q[7:0] <= {txsc_q[7:2], ~shift_busy_q, txsc_q[0]};
                    `AST_RX_STATUS_CONTROL: dat_q[7:0] <= rxsc_q;
                    `AST_BAUD_CONTROL:      dat_q[7:0] <= baud_ctl_q;
                    `AST_BAUD_DIVISOR_LOW:  dat_q[7:0] <= div_lo_q;
                    `AST_BAUD_DIVISOR_HIGH: dat_q[7:0] <= div_hi_q;
                    `AST_IRQ_CONTROL:       dat_q[7:0] <= {4'h0, flag_q, irq_ctl_q};
                    default:                dat_q      <= 32'h0000_0000; // Holding and unmapped read 0
                endcase
            end
        end
    end

    // Control registers; the flag bit is never written by software
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            txsc_q     <= `AST_CTRL_RESET;
            rxsc_q     <= `AST_CTRL_RESET;
            baud_ctl_q <= `AST_CTRL_RESET;
            div_lo_q   <= `AST_CTRL_RESET;
            div_hi_q   <= `AST_CTRL_RESET;
            irq_ctl_q  <= 3'b000;
        end
        else if (wr_lane0)
        begin
            if (sel_wr(wb_adr_i, `AST_TX_STATUS_CONTROL))
                txsc_q <= wb_dat_i[7:0] & 8'hfd; // Shifter-empty bit is read-only
            if (sel_wr(wb_adr_i, `AST_RX_STATUS_CONTROL))
                rxsc_q <= wb_dat_i[7:0];
            if (sel_wr(wb_adr_i, `AST_BAUD_CONTROL))
                baud_ctl_q <= wb_dat_i[7:0] & 8'h1b;
            if (sel_wr(wb_adr_i, `AST_BAUD_DIVISOR_LOW))
                div_lo_q <= wb_dat_i[7:0];
            if (sel_wr(wb_adr_i, `AST_BAUD_DIVISOR_HIGH))
                div_hi_q <= wb_dat_i[7:0];
            if (sel_wr(wb_adr_i, `AST_IRQ_CONTROL))
                irq_ctl_q <= wb_dat_i[2:0];
        end
    end

    // Holding register: captures all nine bits at the write; port off empties it
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hold_data_q  <= 8'h00;
            hold_ninth_q <= 1'b0;
            hold_full_q  <= 1'b0;
        end
        else if (~port_on)
            hold_full_q <= 1'b0;
        else if (hold_wr & async_run)
        begin
            hold_data_q  <= wb_dat_i[7:0];
            hold_ninth_q <= txsc_q[`AST_TX_NINTH_VALUE_BIT];
            hold_full_q  <= 1'b1;
        end
        else if (load_now)
            hold_full_q <= 1'b0;
    end

    // Next state of the frame sequencer
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                // Wait for the next bit boundary so the start bit is full length
                if (load_now)
                    state_d = ST_LEAD;
            end
            ST_LEAD:
            begin
                if (baud_tick_i)
                    state_d = ST_SEND;
            end
            ST_SEND:
            begin
                // A queued character keeps the sequencer sending
                if (last_bit & ~load_now)
                    state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
        // Losing the enable, mode or port aborts at once
        if (~async_run)
            state_d = ST_IDLE;
    end

    // Shifter: frame is stop, data msb..lsb, start; shifted right so lsb leaves first
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q      <= ST_IDLE;
            shifter_q    <= 11'h7ff;
            bits_left_q  <= 4'd0;
            shift_busy_q <= 1'b0;
        end
        else
        begin
            state_q      <= state_d;
            // Busy from the load until the stop bit's closing tick
            shift_busy_q <= (state_d != ST_IDLE);
            if (~async_run)
            begin
                shifter_q   <= 11'h7ff; // Abort leaves mark on the line
                bits_left_q <= 4'd0;
            end
            else if (load_now)
            begin
                // Start bit leads; it reaches the line at the next bit boundary
                if (txsc_q[`AST_TX_NINTH_MODE_BIT])
                begin
                    shifter_q   <= {1'b1, hold_ninth_q, hold_data_q, 1'b0};
                    bits_left_q <= `AST_FRAME_BITS_9;
                end
                else
                begin
                    shifter_q   <= {2'b11, hold_data_q, 1'b0};
                    bits_left_q <= `AST_FRAME_BITS_8;
                end
            end
            else if (sending & baud_tick_i)
            begin
                // One bit per baud tick, lsb first
                shifter_q   <= {1'b1, shifter_q[10:1]};
                bits_left_q <= bits_left_q - 4'd1;
            end
        end
    end

    // Flag is valid two cycles after a write; holds its old value until then
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flag_q      <= 1'b0;
            settle_q    <= 2'd0;
            transmit_enable_ctl_prev_q <= 1'b0;
        end
        else
        begin
            transmit_enable_ctl_prev_q <= tx_en;
            if (hold_wr & async_run)
                settle_q <= `AST_FLAG_SETTLE_CYC - 2'd1;
            else if (settle_q != 2'd0)
                settle_q <= settle_q - 2'd1;
            if (tx_en & ~transmit_enable_ctl_prev_q)
                flag_q <= 1'b1;
            else if (settle_q == 2'd0)
                flag_q <= tx_en & ~hold_full_q;
        end
    end

    // Line, pin driver and interrupt outputs, all registered
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            line_q <= 1'b1;
            oe_q   <= 1'b0;
            irq_q  <= 1'b0;
        end
        else
        begin
            // Invert only in asynchronous mode; clocked mode keeps true polarity
            line_q <= (sending ? shifter_q[0] : 1'b1)
                      ^ (baud_ctl_q[`AST_BC_POLARITY_BIT] & ~clocked);
            oe_q   <= port_on;
            irq_q  <= flag_q & irq_ctl_q[2] & irq_ctl_q[0] & irq_ctl_q[1];
        end
    end

    assign wb_dat_o              = dat_q;
    assign wb_ack_o              = ack_q;
    assign baud_divisor_o        = {div_hi_q, div_lo_q};
    assign high_speed_select_o   = txsc_q[`AST_TX_HISPEED_BIT];
    assign wide_divisor_select_o = baud_ctl_q[`AST_BC_WIDE_DIV_BIT];
    assign transmit_pin_o        = line_q;
    assign transmit_pin_oe_o     = oe_q;
    assign irq_o                 = irq_q;

endmodule
`default_nettype wire

// >>> bench/ast_tx_props.sv
`timescale 1ns/100ps
`default_nettype none
module ast_tx_props
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        transmit_pin_o,
    input wire logic        transmit_pin_oe_o,
    input wire logic        irq_o
);
    logic pol_q;
    logic ie_q;
    logic wr;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Shadows of polarity and of all three enables, kept from bus writes alone
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & wb_sel_i[0];
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pol_q <= 1'b0;
            ie_q  <= 1'b0;
        end
        else if (wr && wb_adr_i == 4'h2)
            pol_q <= wb_dat_i[4];
        else if (wr && wb_adr_i == 4'h6)
            ie_q <= &wb_dat_i[2:0];
    end
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("no ack after request");
    property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
    property p_dat_hi; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_dat_hi: assert property (p_dat_hi) else $error("upper read data not zero");
    property p_hold_rd; wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) >= 4'h5
        && $past(wb_adr_i) != 4'h6 |-> wb_dat_o == 32'h0; endproperty
    a_hold_rd: assert property (p_hold_rd) else $error("hidden place readable");
    property p_oe_on; wr && wb_adr_i == 4'h1 && wb_dat_i[7] |-> ##[1:3] transmit_pin_oe_o;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("pin not driven after port on");
    property p_oe_off; wr && wb_adr_i == 4'h1 && !wb_dat_i[7] |-> ##[1:3] !transmit_pin_oe_o;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin still driven");
    property p_irq_gate; !ie_q && !$past(ie_q) |-> !irq_o; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while gated");
    property p_idle_mark; !transmit_pin_oe_o && !$past(transmit_pin_oe_o, 2) && !pol_q
        && !$past(pol_q) |-> transmit_pin_o; endproperty
    a_idle_mark: assert property (p_idle_mark) else $error("idle line not mark");
    c_irq: cover property ($rose(irq_o));
    c_oe_off: cover property ($fell(transmit_pin_oe_o));
    c_start: cover property (transmit_pin_oe_o && $fell(transmit_pin_o));
endmodule
bind ast_transmitter ast_tx_props u_props
(
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .transmit_pin_o(transmit_pin_o),
    .transmit_pin_oe_o(transmit_pin_oe_o), .irq_o(irq_o)
);
`default_nettype wire

// >>> bench/ast_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module ast_rx_model
(
    input  wire logic       clk_i,
    input  wire logic       tick_i,
    input  wire logic       line_i,
    input  wire logic       inv_i,
    input  wire logic       nine_i,
    output var  logic [8:0] word_o,
    output var  logic       stop_o,
    output var  int         count_o
);
    logic [3:0] ph_q  = 4'h0;
    logic [3:0] n_q   = 4'h0;
    logic [9:0] sh_q  = 10'h0;
    logic       inv_q = 1'b0;
    logic       lv;
    int         cnt_q = 0;
    // Works on mark-high levels, so inversion is undone here
    assign lv = line_i ^ inv_i;
    assign count_o = cnt_q;
    // Samples mid-bit, eight clocks after each tick, so a short bit shows
    always @(posedge clk_i)
    begin
        ph_q  <= tick_i ? 4'h0 : ph_q + 4'h1;
        inv_q <= inv_i;
        if (inv_i != inv_q)
            n_q <= 4'h0; // Drop a false start seen while polarity swaps
        else if (ph_q == 4'h7 && n_q == 4'h0)
            n_q <= {3'h0, !lv}; // Start bit is space
        else if (ph_q == 4'h7 && n_q <= (nine_i ? 4'h9 : 4'h8))
        begin
            sh_q <= {lv, sh_q[9:1]}; // First bit lands lowest
            n_q  <= n_q + 4'h1;
        end
        else if (ph_q == 4'h7)
        begin
            word_o  <= nine_i ? sh_q[9:1] : {1'b0, sh_q[9:2]};
            stop_o  <= lv;
            cnt_q   <= cnt_q + 1;
            n_q     <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_ast_transmitter.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ast_transmitter;
    logic        clk_i, rst_i, cyc, we, tick, inv, nine;
    logic [3:0]  adr, tc;
    logic [7:0]  d, rd;
    wire  [31:0] dat_o;
    wire  [15:0] div;
    wire  [8:0]  rw;
    wire         ack, pin, oe, irq, hs, wd, rs;
    int          rc, err_total, comparisons, cyc_n;
    ast_transmitter uut
    (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h0, d}), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .baud_tick_i(tick), .baud_divisor_o(div), .high_speed_select_o(hs),
        .wide_divisor_select_o(wd), .transmit_pin_o(pin), .transmit_pin_oe_o(oe), .irq_o(irq)
    );
    ast_rx_model rx
    (
        .clk_i(clk_i), .tick_i(tick), .line_i(pin), .inv_i(inv), .nine_i(nine),
        .word_o(rw), .stop_o(rs), .count_o(rc)
    );
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Bit tick every 16 clocks; the cycle ceiling stops a hung run
    always @(posedge clk_i)
    begin
        tc <= tc + 4'h1;
        tick <= tc == 4'hf;
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000)
        begin
            err_total++;
            report_and_stop;
        end
    end
    task chk(input logic [15:0] s, input logic [15:0] e);
        begin
            comparisons++;
            if (s !== e)
            begin
                err_total++;
                $display("[FAIL] %0t seen %h expected %h", $time, s, e);
            end
        end
    endtask
    // One classic cycle: hold everything until ack is sampled, then release
    task bus(input logic [3:0] a, input logic w, input logic [7:0] v);
        int n;
        begin
            n = 0;
            @(posedge clk_i);
            cyc <= 1'b1;
            we <= w;
            adr <= a;
            d <= v;
            do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
            rd = dat_o[7:0];
            cyc <= 1'b0;
            we <= 1'b0;
            chk(16'(n < 20), 16'h1);
        end
    endtask
    task poll(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        int k;
        begin
            k = 0;
            do begin bus(a, 1'b0, 8'h0); k++; end while ((rd & m) !== e && k < 40);
            chk(16'(rd & m), 16'(e));
        end
    endtask
    task wait_rx(input int n);
        int k;
        begin
            k = 0;
            while (rc < n && k < 600) begin @(posedge clk_i); k++; end
            chk(16'(rc), 16'(n));
        end
    endtask
    task t_regs;
        begin
            poll(4'h0, 8'hff, 8'h02);
            poll(4'h5, 8'hff, 8'h00);
            poll(4'h7, 8'hff, 8'h00);
            bus(4'h3, 1'b1, 8'h34);
            bus(4'h4, 1'b1, 8'h12);
            bus(4'h2, 1'b1, 8'h08);
            bus(4'h0, 1'b1, 8'h04);
            chk(div, 16'h1234);
            chk(16'({hs, wd}), 16'h3);
        end
    endtask
    task t_enable;
        begin
            bus(4'h1, 1'b1, 8'h80);
            poll(4'h6, 8'h08, 8'h00);
            chk(16'(oe), 16'h1);
            bus(4'h0, 1'b1, 8'h20);
            poll(4'h6, 8'h08, 8'h08);
            bus(4'h6, 1'b1, 8'h00);
            poll(4'h6, 8'h08, 8'h08);
            bus(4'h6, 1'b1, 8'h07);
            poll(4'h6, 8'h08, 8'h08);
            chk(16'(irq), 16'h1);
            bus(4'h6, 1'b1, 8'h03);
            @(posedge clk_i);
            chk(16'(irq), 16'h0);
        end
    endtask
    task t_frames;
        begin
            bus(4'h5, 1'b1, 8'ha5);
            bus(4'h5, 1'b1, 8'h3c);
            poll(4'h6, 8'h08, 8'h00);
            poll(4'h0, 8'h02, 8'h00);
            wait_rx(1);
            chk(16'(rw), 16'h00a5);
            chk(16'(rs), 16'h1);
            wait_rx(2);
            chk(16'(rw), 16'h003c);
            poll(4'h0, 8'h02, 8'h02);
            poll(4'h6, 8'h08, 8'h08);
        end
    endtask
    task t_ninth_inv;
        begin
            bus(4'h0, 1'b1, 8'h61);
            nine <= 1'b1;
            bus(4'h5, 1'b1, 8'h5a);
            wait_rx(3);
            chk(16'(rw), 16'h015a);
            poll(4'h0, 8'h02, 8'h02);
            bus(4'h0, 1'b1, 8'h20);
            nine <= 1'b0;
            bus(4'h2, 1'b1, 8'h18);
            poll(4'h0, 8'h02, 8'h02);
            inv <= 1'b1;
            chk(16'(pin), 16'h0);
            bus(4'h5, 1'b1, 8'h81);
            wait_rx(4);
            chk(16'(rw), 16'h0081);
            bus(4'h0, 1'b1, 8'h30);
            @(posedge clk_i);
            chk(16'(pin), 16'h1);
            bus(4'h0, 1'b1, 8'h20);
        end
    endtask
    task t_abort;
        begin
            bus(4'h5, 1'b1, 8'hff);
            poll(4'h0, 8'h02, 8'h00);
            bus(4'h1, 1'b1, 8'h00);
            poll(4'h0, 8'h02, 8'h02);
            chk(16'(oe), 16'h0);
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial
    begin
        {cyc, we, tick, inv, nine, adr, tc, d} = '0;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_enable;
        t_frames;
        t_ninth_inv;
        t_abort;
        report_and_stop;
    end
endmodule
`default_nettype wire
